// ---- src/can_guard_regs.svh ----
// constants for the can transceiver fault guard
`ifndef CAN_GUARD_REGS_SVH
`define CAN_GUARD_REGS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define FT_CLK_NS 4
`define FT_CLK_MHZ 250

// ----------------------------------------
// timeouts, nominal figures in microseconds
// ----------------------------------------
`define FT_TXDOM_TIMEOUT_US 700
`define FT_BUSDOM_TIMEOUT_US 700
`define FT_TMO_W 18
`define FT_TXDOM_TIMEOUT_CYC (`FT_TXDOM_TIMEOUT_US * `FT_CLK_MHZ)
`define FT_BUSDOM_TIMEOUT_CYC (`FT_BUSDOM_TIMEOUT_US * `FT_CLK_MHZ)

// ----------------------------------------
// follow window: worst loop delay tx to rx, in ns, rounded up to cycles
// ----------------------------------------
`define FT_FOLLOW_NS 275
`define FT_FOLLOW_CYC ((`FT_FOLLOW_NS + `FT_CLK_NS - 1) / `FT_CLK_NS)
`define FT_WIN_W 7
`define FT_MISS_LIMIT 4
`define FT_MISS_W 3

// ----------------------------------------
// logic levels on tx and rx
// ----------------------------------------
`define FT_LVL_DOMINANT 1'b0
`define FT_LVL_RECESSIVE 1'b1

`endif

// ---- src/can_guard_pkg.sv ----
// types shared by the can transceiver fault guard
`include "can_guard_regs.svh"

package can_guard_pkg;

  typedef logic [`FT_TMO_W-1:0] tmo_cnt_t;
  typedef logic [`FT_WIN_W-1:0] win_cnt_t;
  typedef logic [`FT_MISS_W-1:0] miss_cnt_t;

  // latched faults, one bit per supervised condition
  typedef struct packed {
    logic tx_timeout;
    logic bus_recessive;
    logic bus_dominant;
    logic echo_recessive;
  } fault_t;

  // host side control from the serial channel
  typedef struct packed {
    logic fault_handling_disable;
    logic status_clear;
  } ctrl_t;

  typedef enum logic {
    FOLLOW_IDLE,
    FOLLOW_WATCH
  } follow_state_t;

endpackage

// ---- src/dominant_timer.sv ----
// saturating timer that measures how long a level stays dominant
`include "can_guard_regs.svh"

module dominant_timer #(
  parameter can_guard_pkg::tmo_cnt_t LIMIT = can_guard_pkg::tmo_cnt_t'(`FT_TXDOM_TIMEOUT_CYC)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic mon,
  output logic expired
);
  import can_guard_pkg::*;

  tmo_cnt_t cnt_q;
  tmo_cnt_t cnt_d;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // restart on recessive, hold at the limit
  always_comb begin
    if (!mon) begin
      cnt_d = '0;
    end else if (cnt_q != LIMIT) begin
      cnt_d = tmo_cnt_t'(cnt_q + 1'b1);
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == LIMIT);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_timer_restart: assert property (!mon |=> cnt_q == '0 && !expired)
    else $error("timer did not restart on recessive");
  a_timer_fires: assert property (mon && cnt_q == LIMIT - 1'b1 |=> expired)
    else $error("timer did not expire at the limit");
  a_timer_holds: assert property (expired && mon |=> expired)
    else $error("expiry dropped while still dominant");

endmodule // dominant_timer

// ---- src/follow_checker.sv ----
// counts dominant transmit edges that a feedback level fails to follow
`include "can_guard_regs.svh"

module follow_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic tx_dom,
  input wire logic follower_dom,
  input wire logic clear,
  output logic tripped
);
  import can_guard_pkg::*;

  localparam int FOLLOW_MAX = `FT_FOLLOW_CYC;

  follow_state_t state_q;
  follow_state_t state_d;
  win_cnt_t win_q;
  win_cnt_t win_d;
  miss_cnt_t miss_q;
  miss_cnt_t miss_d;
  logic trip_d;
  logic trip_q;

  // ----------------------------------------
  // window and miss counter
  // ----------------------------------------
  // window fits inside one bit at 1 Mbit/s, so no false misses
  always_comb begin
    state_d = state_q;
    win_d = win_q;
    miss_d = miss_q;
    trip_d = 1'b0;
    case (state_q)
      FOLLOW_IDLE: begin
        if (start) begin
          state_d = FOLLOW_WATCH;
          win_d = '0;
        end
      end
      FOLLOW_WATCH: begin
        win_d = win_cnt_t'(win_q + 1'b1);
        if (follower_dom) begin
          state_d = FOLLOW_IDLE;
          miss_d = '0;
        end else if (!tx_dom || win_q == win_cnt_t'(`FT_FOLLOW_CYC - 1)) begin
          state_d = FOLLOW_IDLE;
          if (miss_q != miss_cnt_t'(`FT_MISS_LIMIT)) begin
            miss_d = miss_cnt_t'(miss_q + 1'b1);
            trip_d = (miss_q == miss_cnt_t'(`FT_MISS_LIMIT - 1));
          end
        end
      end
      default: begin
        state_d = FOLLOW_IDLE;
      end
    endcase
    // a trip found in this cycle survives the clear, so the set wins
    if (clear) begin
      state_d = FOLLOW_IDLE;
      miss_d = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= FOLLOW_IDLE;
      win_q <= '0;
      miss_q <= '0;
      trip_q <= 1'b0;
    end else begin
      state_q <= state_d;
      win_q <= win_d;
      miss_q <= miss_d;
      trip_q <= trip_d;
    end
  end

  // one pulse per trip: a stale full count must not re-set a flag being cleared
  assign tripped = trip_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_last_miss;
    state_q == FOLLOW_WATCH && !follower_dom && !clear &&
      win_q == win_cnt_t'(`FT_FOLLOW_CYC - 1) && miss_q == miss_cnt_t'(`FT_MISS_LIMIT - 1);
  endsequence

  a_miss_trips: assert property (s_last_miss |=> tripped)
    else $error("fourth miss did not trip");
  a_follow_resets: assert property (state_q == FOLLOW_WATCH && follower_dom |=> miss_q == '0)
    else $error("miss count kept after a follow");
  a_window_bound: assert property ($rose(state_q == FOLLOW_WATCH) |-> ##[1:FOLLOW_MAX] state_q == FOLLOW_IDLE)
    else $error("follow window overran");

endmodule // follow_checker

// ---- src/can_transceiver_fault_guard.sv ----
// digital control and fault supervision of a high speed can transceiver
// ----------------------------------------
// ----------------------------------------
`include "can_guard_regs.svh"

module can_transceiver_fault_guard #(
  parameter can_guard_pkg::tmo_cnt_t TX_DOM_TIMEOUT_CYC = can_guard_pkg::tmo_cnt_t'(`FT_TXDOM_TIMEOUT_CYC),
  parameter can_guard_pkg::tmo_cnt_t BUS_DOM_TIMEOUT_CYC = can_guard_pkg::tmo_cnt_t'(`FT_BUSDOM_TIMEOUT_CYC)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic chip_reset_n,
  input wire logic tx_level,
  output logic rx_level,
  input wire logic bus_dominant,
  input wire logic rx_echo,
  input wire can_guard_pkg::ctrl_t ctrl,
  output logic drive_dominant,
  output logic tx_disabled,
  output logic fault_status,
  output can_guard_pkg::fault_t fault_flags
);
  import can_guard_pkg::*;

  // ----------------------------------------
  // transmit level decode
  // ----------------------------------------
  logic tx_dom;
  logic tx_dom_q;
  logic tx_dom_d;
  logic tx_fall;
  logic echo_dom;
  logic disable_on;

  // tx ignored while the device is held in reset
  assign tx_dom = (tx_level == `FT_LVL_DOMINANT) && chip_reset_n;
  assign echo_dom = (rx_echo == `FT_LVL_DOMINANT);
  assign disable_on = ctrl.fault_handling_disable;
  assign tx_fall = tx_dom && !tx_dom_q;
  assign tx_dom_d = tx_dom;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_dom_q <= 1'b0;
    end else begin
      tx_dom_q <= tx_dom_d;
    end
  end

  // ----------------------------------------
  // fault detectors
  // ----------------------------------------
  logic tx_tmo;
  logic bus_tmo;
  logic bus_miss;
  logic echo_miss;
  logic follow_clear;

  // a clear or disabled supervision empties both miss counters
  assign follow_clear = ctrl.status_clear || disable_on;

  // tx held dominant too long
  dominant_timer #(
    .LIMIT(TX_DOM_TIMEOUT_CYC)
  ) u_tx_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .mon(tx_dom),
    .expired(tx_tmo)
  );

  // bus held dominant too long
  dominant_timer #(
    .LIMIT(BUS_DOM_TIMEOUT_CYC)
  ) u_bus_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .mon(bus_dominant),
    .expired(bus_tmo)
  );

  // bus does not follow dominant tx
  follow_checker u_bus_follow (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(tx_fall),
    .tx_dom(tx_dom),
    .follower_dom(bus_dominant),
    .clear(follow_clear),
    .tripped(bus_miss)
  );

  // rx echo does not follow dominant tx
  follow_checker u_echo_follow (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(tx_fall),
    .tx_dom(tx_dom),
    .follower_dom(echo_dom),
    .clear(follow_clear),
    .tripped(echo_miss)
  );

  // ----------------------------------------
  // fault latch
  // ----------------------------------------
  fault_t set_now;
  fault_t flags_q;
  fault_t flags_d;
  logic status_d;
  logic status_q;
  logic tx_off;

  // set wins over a clear in the same cycle
  always_comb begin
    set_now.tx_timeout = tx_tmo;
    set_now.bus_recessive = bus_miss;
    set_now.bus_dominant = bus_tmo;
    set_now.echo_recessive = echo_miss;
    if (disable_on) begin
      set_now = '0;
    end
    flags_d = ctrl.status_clear ? set_now : (flags_q | set_now);
    status_d = |flags_d;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags_q <= '0;
      status_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      status_q <= status_d;
    end
  end

  // stuck dominant alone leaves the transmitter running
  assign tx_off = (flags_q.tx_timeout || flags_q.bus_recessive || flags_q.echo_recessive)
    && !disable_on;

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  logic drive_d;
  logic drive_q;
  logic rx_d;
  logic rx_q;

  always_comb begin
    drive_d = tx_dom && !tx_off;
    rx_d = bus_dominant ? `FT_LVL_DOMINANT : `FT_LVL_RECESSIVE;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      drive_q <= 1'b0;
      rx_q <= `FT_LVL_RECESSIVE;
    end else begin
      drive_q <= drive_d;
      rx_q <= rx_d;
    end
  end

  assign drive_dominant = drive_q;
  assign rx_level = rx_q;
  assign tx_disabled = tx_off;
  assign fault_status = status_q;
  assign fault_flags = flags_q;

  // ----------------------------------------
  // check helpers
  // ----------------------------------------
  tmo_cnt_t run_q;
  tmo_cnt_t run_d;

  // length of the current dominant drive, zero while supervision is off
  always_comb begin
    if (!drive_dominant || disable_on) begin
      run_d = '0;
    end else if (run_q != '1) begin
      run_d = tmo_cnt_t'(run_q + 1'b1);
    end else begin
      run_d = run_q; // saturates, never wraps
    end
  end

  // registers the run length for the bound below
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      run_q <= '0;
    end else begin
      run_q <= run_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_latched_off;
    tx_off && !ctrl.status_clear && !disable_on;
  endsequence

  sequence s_tx_timeout_hit;
    tx_tmo && !disable_on;
  endsequence

  // a clear with no fault condition standing in the same cycle
  sequence s_quiet_clear;
    ctrl.status_clear && !tx_tmo && !bus_tmo && !bus_miss && !echo_miss;
  endsequence

  a_tx_maps_bus: assert property (@(posedge clk_sys) disable iff (reset)
    chip_reset_n && tx_level == `FT_LVL_DOMINANT && !tx_off |=> drive_dominant)
    else $error("dominant tx did not drive the bus");
  a_rx_reports_bus: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 rx_level == ($past(bus_dominant) ? `FT_LVL_DOMINANT : `FT_LVL_RECESSIVE))
    else $error("rx level does not match bus state");
  a_reset_recessive: assert property (@(posedge clk_sys) disable iff (reset)
    !chip_reset_n |=> !drive_dominant)
    else $error("driver active during device reset");
  a_single_flag: assert property (@(posedge clk_sys) disable iff (reset)
    fault_status == (|fault_flags))
    else $error("bus fault flag disagrees with latched faults");
  a_disable_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    disable_on |=> (fault_flags & ~$past(fault_flags)) == '0)
    else $error("fault latched while handling disabled");
  a_tx_timeout_off: assert property (@(posedge clk_sys) disable iff (reset)
    s_tx_timeout_hit |=> fault_flags.tx_timeout && fault_status ##1 !drive_dominant || disable_on)
    else $error("tx timeout did not disable the transmitter");
  a_stays_off: assert property (@(posedge clk_sys) disable iff (reset)
    s_latched_off ##1 !disable_on |-> tx_off)
    else $error("transmitter re-enabled without a clear");
  a_stuck_keeps_tx: assert property (@(posedge clk_sys) disable iff (reset)
    fault_flags.bus_dominant && !fault_flags.tx_timeout && !fault_flags.bus_recessive
      && !fault_flags.echo_recessive |-> !tx_off)
    else $error("stuck dominant shut the transmitter");
  a_echo_off: assert property (@(posedge clk_sys) disable iff (reset)
    echo_miss && !disable_on |=> fault_flags.echo_recessive && tx_disabled)
    else $error("echo fault did not disable the transmitter");

  // ----------------------------------------
  // checks: latch and clear
  // ----------------------------------------
  a_clear_empties: assert property (@(posedge clk_sys) disable iff (reset)
    s_quiet_clear |=> fault_flags == '0 && !fault_status && !tx_disabled)
    else $error("clear left a fault latched");
  a_flags_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !ctrl.status_clear |=> (fault_flags & $past(fault_flags)) == $past(fault_flags))
    else $error("latched fault dropped without a clear");
  a_bus_miss_latch: assert property (@(posedge clk_sys) disable iff (reset)
    bus_miss && !disable_on |=> fault_flags.bus_recessive && fault_status)
    else $error("bus follow fault not latched");
  a_stuck_latch: assert property (@(posedge clk_sys) disable iff (reset)
    bus_tmo && !disable_on |=> fault_flags.bus_dominant && fault_status)
    else $error("stuck dominant not latched");

  // ----------------------------------------
  // checks: a flag only rises after its own detector
  // ----------------------------------------
  a_tx_flag_cause: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(fault_flags.tx_timeout) |-> $past(tx_tmo))
    else $error("tx timeout flag without an expiry");
  a_stuck_flag_cause: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(fault_flags.bus_dominant) |-> $past(bus_tmo))
    else $error("stuck dominant flag without an expiry");
  a_bus_flag_cause: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(fault_flags.bus_recessive) |-> $past(bus_miss))
    else $error("bus follow flag without a trip");
  a_echo_flag_cause: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(fault_flags.echo_recessive) |-> $past(echo_miss))
    else $error("echo flag without a trip");

  // ----------------------------------------
  // checks: transmit path
  // ----------------------------------------
  a_tx_recessive: assert property (@(posedge clk_sys) disable iff (reset)
    tx_level == `FT_LVL_RECESSIVE |=> !drive_dominant)
    else $error("recessive tx drove the bus");
  a_off_blocks_tx: assert property (@(posedge clk_sys) disable iff (reset)
    tx_disabled |=> !drive_dominant)
    else $error("disabled transmitter drove the bus");
  a_disable_drives: assert property (@(posedge clk_sys) disable iff (reset)
    disable_on && chip_reset_n && tx_level == `FT_LVL_DOMINANT |=> drive_dominant)
    else $error("supervision shut the transmitter while disabled");
  // the timeout plus one cycle of latch before the driver register lets go
  a_drive_bounded: assert property (@(posedge clk_sys) disable iff (reset)
    run_q <= TX_DOM_TIMEOUT_CYC + 1'b1)
    else $error("dominant drive outlived the tx timeout");

endmodule // can_transceiver_fault_guard

// ---- bench/can_bus_model.sv ----
// behavioural model of the can bus and the rx echo path around the guard
module can_bus_model (
  input wire logic clk_sys,
  input wire logic drive_dominant,
  input wire logic rx_level,
  input wire logic [1:0] mode,
  input wire logic [5:0] delay,
  output logic bus_dominant,
  output logic rx_echo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] hist_q;

  // ----------------------------------------
  // delay line of the driver state
  // ----------------------------------------
  initial hist_q = 64'h0;
  always @(posedge clk_sys) begin
    hist_q <= {hist_q[62:0], drive_dominant};
  end

  // bus follows driver late; modes 1..3 inject faults
  always_comb begin
    bus_dominant = hist_q[delay];
    if (mode == 2'h1) bus_dominant = 1'b0; // stuck recessive
    if (mode == 2'h2) bus_dominant = 1'b1; // stuck dominant
    rx_echo = (mode == 2'h3) ? 1'b1 : rx_level; // clamped echo
  end
endmodule // can_bus_model

// ---- bench/can_transceiver_fault_guard_bench.sv ----
// self-checking bench for the can transceiver fault guard
module can_transceiver_fault_guard_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import can_guard_pkg::*;

  localparam int TX_LIM = 100;
  localparam int BUS_LIM = 150;
  logic clk_sys, reset, chip_reset_n, tx_level, rx_level, bus_dominant, rx_echo;
  logic drive_dominant, tx_disabled, fault_status, lvl;
  ctrl_t ctrl;
  fault_t fault_flags;
  logic [1:0] mode;
  logic [5:0] delay;
  logic [31:0] seed;
  int mismatches, tests_run, cycles, len;

  can_transceiver_fault_guard #(
    .TX_DOM_TIMEOUT_CYC(tmo_cnt_t'(TX_LIM)),
    .BUS_DOM_TIMEOUT_CYC(tmo_cnt_t'(BUS_LIM))
  ) DUT (
    .clk_sys(clk_sys), .reset(reset), .chip_reset_n(chip_reset_n), .tx_level(tx_level),
    .rx_level(rx_level), .bus_dominant(bus_dominant), .rx_echo(rx_echo), .ctrl(ctrl),
    .drive_dominant(drive_dominant), .tx_disabled(tx_disabled), .fault_status(fault_status),
    .fault_flags(fault_flags)
  );

  can_bus_model far_side (
    .clk_sys(clk_sys), .drive_dominant(drive_dominant), .rx_level(rx_level),
    .mode(mode), .delay(delay), .bus_dominant(bus_dominant), .rx_echo(rx_echo)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected latched flags for a fault mode or a tx timeout
  function automatic fault_t flags_of(input logic [1:0] m, input logic tmo);
    fault_t f;
    f.tx_timeout = tmo;
    f.bus_recessive = (m == 2'h1);
    f.bus_dominant = (m == 2'h2);
    f.echo_recessive = (m == 2'h1) || (m == 2'h3);
    return f;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // dominant then recessive bits, each l cycles
  task automatic pulses(input int n, input int l);
    repeat (n) begin
      tx_level <= 1'b0;
      cyc(l);
      tx_level <= 1'b1;
      cyc(l);
    end
  endtask

  // host clear over the serial channel
  task automatic clear_status();
    ctrl.status_clear <= 1'b1;
    cyc(1);
    ctrl.status_clear <= 1'b0;
    cyc(1);
    #1;
    chk(fault_flags, 32'h0);
    chk(tx_disabled, 32'h0);
    cyc(1);
  endtask

  task automatic end_sim();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial cycles = 0;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    chip_reset_n = 1'b0;
    tx_level = 1'b1;
    ctrl = '0;
    mode = 2'h0;
    delay = 6'h2;
    seed = 32'd99394;
    mismatches = 0;
    tests_run = 0;
    cyc(20);
    // tx held dominant while chip reset is low
    reset <= 1'b0;
    tx_level <= 1'b0;
    cyc(TX_LIM + 20);
    #1;
    chk(drive_dominant, 32'h0);
    chk(rx_level, 32'h1);
    chk(fault_status, 32'h0);
    cyc(1);
    chip_reset_n <= 1'b1;
    tx_level <= 1'b1;
    cyc(5);
    // random bit lengths near the window, alternating levels
    for (int i = 0; i < 40; i++) begin
      lvl = i[0];
      len = 70 + int'(rnd() % 21);
      if (!lvl) delay <= 6'(rnd() % 40);
      tx_level <= lvl;
      cyc(len - 1);
      #1;
      chk(drive_dominant, {31'h0, !lvl});
      chk(rx_level, lvl);
      cyc(1);
    end
    #1;
    chk(fault_status, 32'h0);
    cyc(1);
    // dominant tx timeout
    tx_level <= 1'b0;
    cyc(TX_LIM - 1);
    #1;
    chk(fault_status, 32'h0);
    cyc(4);
    #1;
    chk(fault_flags, flags_of(2'h0, 1'b1));
    chk(fault_status, 32'h1);
    chk(drive_dominant, 32'h0);
    cyc(1);
    tx_level <= 1'b1;
    cyc(10);
    tx_level <= 1'b0;
    cyc(20);
    #1;
    chk(drive_dominant, 32'h0);
    cyc(1);
    tx_level <= 1'b1;
    cyc(2);
    clear_status();
    // supervision disabled: long dominant and missed follows
    ctrl.fault_handling_disable <= 1'b1;
    tx_level <= 1'b0;
    cyc(BUS_LIM + 50);
    #1;
    chk(drive_dominant, 32'h1);
    cyc(1);
    tx_level <= 1'b1;
    mode <= 2'h1;
    pulses(4, 80);
    #1;
    chk(fault_status, 32'h0);
    cyc(1);
    mode <= 2'h0;
    ctrl.fault_handling_disable <= 1'b0;
    cyc(10);
    clear_status();
    // three misses, one follow, three misses: no trip
    mode <= 2'h1;
    pulses(3, 80);
    mode <= 2'h0;
    pulses(1, 80);
    mode <= 2'h1;
    pulses(3, 80);
    #1;
    chk(fault_status, 32'h0);
    cyc(1);
    pulses(1, 80);
    #1;
    chk(fault_flags, flags_of(2'h1, 1'b0));
    chk(tx_disabled, 32'h1);
    cyc(1);
    mode <= 2'h0;
    clear_status();
    // echo clamped recessive
    mode <= 2'h3;
    pulses(4, 80);
    #1;
    chk(fault_flags, flags_of(2'h3, 1'b0));
    chk(tx_disabled, 32'h1);
    cyc(1);
    mode <= 2'h0;
    clear_status();
    // bus stuck dominant
    mode <= 2'h2;
    cyc(BUS_LIM + 5);
    #1;
    chk(fault_flags, flags_of(2'h2, 1'b0));
    chk(tx_disabled, 32'h0);
    chk(rx_level, 32'h0);
    cyc(1);
    mode <= 2'h0;
    cyc(3);
    clear_status();
    end_sim();
  end
endmodule // can_transceiver_fault_guard_bench
